// ---- hw/hbp_pkg.sv ----
// constants shared by the host bus display memory port
package hbp_pkg;
    // command codes
    localparam logic [7:0] CMD_SYS_CONFIG   = 8'h40;
    localparam logic [7:0] CMD_SLEEP_ENTRY  = 8'h53;
    localparam logic [7:0] CMD_MEM_WRITE    = 8'h42;
    localparam logic [7:0] CMD_MEM_READ     = 8'h43;
    localparam logic [7:0] CMD_CURSOR_SET   = 8'h46;
    localparam logic [7:0] CMD_CURSOR_GET   = 8'h47;
    localparam logic [5:0] CMD_STEP_DIR_TOP = 6'h13;
    // step direction codes, low two bits of the direction command
    localparam logic [1:0] DIR_RIGHT        = 2'h0;
    localparam logic [1:0] DIR_LEFT         = 2'h1;
    localparam logic [1:0] DIR_UP           = 2'h2;
    localparam logic [1:0] DIR_DOWN         = 2'h3;
    // status byte layout
    localparam int         STATUS_FLAG_BIT  = 6;
    // reset values
    localparam logic [15:0] CURSOR_RST      = 16'h0000;
    localparam logic [1:0]  DIR_RST         = 2'h0;
    localparam logic [7:0]  CMD_RST         = 8'h00;
    // write stream buffer
    localparam int         FIFO_DEPTH       = 16;
    localparam int         FIFO_WIDTH       = 24;
    typedef enum logic [3:0] {
        HBP_PARAM  = 4'h1,
        HBP_MEMORY_WRITE_CMD = 4'h2,
        HBP_MEMORY_READ_CMD  = 4'h4,
        HBP_CGET   = 4'h8
    } hbp_mode_t;
endpackage : hbp_pkg

// ---- hw/hbp_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module hbp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : hbp_fifo

// ---- hw/hbp_port.sv ----
// host parallel bus port: strobe decode, commands, cursor stepping, memory streams
`timescale 1ns/100ps
// How it works
// RULE_01: after memory write command, each data byte stored at cursor, cursor steps; a byte written while the buffer is full is dropped, cursor holds.
// RULE_02: host issues memory write once, then writes bytes back to back.
// RULE_03: memory read command enters output state and preloads byte at cursor.
// RULE_04: each buffer read steps cursor and fetches next byte into buffer.
// RULE_05: with cursor displayed, read data comes from two steps ahead.
// RULE_06: two style selects choose separate strobes or direction plus enable.
// RULE_07: separate strobes: select/read/write decode to the four cycle kinds.
// RULE_08: direction-enable: enable high qualifies, direction and select decode.
// RULE_09: every command completes within one bus cycle, no polling needed. Memory read preload waits for buffer drain and memory grant.
// RULE_10: status read drives the display status flag on data bit 6.
// RULE_11: flag high during line idle cycles, low while display is read.
// RULE_12: in sleep, only system configuration and sleep entry are accepted.
// RULE_13: host repeats data reads only if its loop exceeds the cycle time.
// RULE_14: host should write display memory during retrace periods.
// RULE_15: host writes only inside window after line latch pulse rising edge.
// RULE_16: host should time writes from line latch pulse falling edge.
// RULE_17: host should blank display before rewriting the whole memory.
// RULE_18: step is +1, -1, minus row pitch or plus row pitch by direction bits.
// RULE_19: cursor changes only by cursor set or automatic stepping.
// RULE_20: after cursor get command, reads return low byte then high byte.
// RULE_21: data bus driven only during a qualified read with chip select.
// RULE_22: data writes outside memory write mode are parameters of last command.
module hbp_port (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    // host bus
    input  wire logic        bus_style_select_a_i,
    input  wire logic        bus_style_select_b_i,
    input  wire logic        chip_select_b_i,
    input  wire logic        register_select_i,
    input  wire logic        strobe_a_i,
    input  wire logic        strobe_b_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             data_oe_b_o,
    output logic             host_write_ready_o,
    // display timing and configuration from the scan logic
    input  wire logic        scan_reading_i,
    input  wire logic        cursor_shown_i,
    input  wire logic [15:0] row_pitch_i,
    // display memory port
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic      [15:0] mem_addr_o,
    output logic      [7:0]  mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    // commands and parameters to the other blocks
    output logic             cmd_valid_o,
    output logic      [7:0]  cmd_code_o,
    output logic             param_valid_o,
    output logic      [7:0]  param_data_o,
    output logic      [7:0]  param_index_o,
    output logic             sleep_o,
    output logic      [15:0] cursor_addr_o
);
    // ----------------------------------------------------------------
    // strobe decode
    // ----------------------------------------------------------------
    // only select a high with select b low picks direction plus enable;
    // every other strap pair keeps separate strobes
    wire dir_en_mode = bus_style_select_a_i && !bus_style_select_b_i;  // RULE_06
    wire sep_rd      = !chip_select_b_i && !strobe_a_i && strobe_b_i;  // RULE_07
    wire sep_wr      = !chip_select_b_i && strobe_a_i && !strobe_b_i;  // RULE_07
    wire de_rd       = !chip_select_b_i && strobe_b_i && strobe_a_i;   // RULE_08
    wire de_wr       = !chip_select_b_i && strobe_b_i && !strobe_a_i;  // RULE_08
    wire rd_act      = dir_en_mode ? de_rd : sep_rd;
    wire wr_act      = dir_en_mode ? de_wr : sep_wr;

    logic       rd_act_q;
    logic       wr_act_q;
    logic       rd_sel_q;
    logic       wr_sel_q;
    logic [7:0] wr_data_q;

    // writes are taken when the strobe ends, from data held in the last
    // active cycle; reads complete at the strobe end as well
    wire wr_done    = wr_act_q && !wr_act;
    wire rd_done    = rd_act_q && !rd_act;
    wire cmd_wr     = wr_done && wr_sel_q;
    wire dat_wr     = wr_done && !wr_sel_q;
    wire dat_rd     = rd_done && rd_sel_q;

    // ----------------------------------------------------------------
    // command handling
    // ----------------------------------------------------------------
    hbp_pkg::hbp_mode_t mode_q;
    logic [7:0]         last_cmd_q;
    logic [7:0]         pidx_q;
    logic               sleep_q;
    logic [1:0]         dir_q;
    logic [15:0]        cursor_q;
    logic               cget_hi_q;
    logic               fetch_pend_q;
    logic [15:0]        fetch_addr_q;
    logic [7:0]         buf_q;
    logic [7:0]         out_q;
    logic               flag_q;

    wire cmd_ok = !sleep_q || (wr_data_q == hbp_pkg::CMD_SYS_CONFIG)
                  || (wr_data_q == hbp_pkg::CMD_SLEEP_ENTRY);          // RULE_12
    wire cmd_take   = cmd_wr && cmd_ok;
    wire is_memory_write_cmd  = cmd_take && (wr_data_q == hbp_pkg::CMD_MEM_WRITE);
    wire is_memory_read_cmd   = cmd_take && (wr_data_q == hbp_pkg::CMD_MEM_READ);
    wire is_cget    = cmd_take && (wr_data_q == hbp_pkg::CMD_CURSOR_GET);
    wire is_dir     = cmd_take && (wr_data_q[7:2] == hbp_pkg::CMD_STEP_DIR_TOP);
    wire param_ok   = !sleep_q || (last_cmd_q == hbp_pkg::CMD_SYS_CONFIG);
    wire param_take = dat_wr && (mode_q != hbp_pkg::HBP_MEMORY_WRITE_CMD) && param_ok; // RULE_22
    wire cset_lo    = param_take && (last_cmd_q == hbp_pkg::CMD_CURSOR_SET)
                      && (pidx_q == 8'h00);
    wire cset_hi    = param_take && (last_cmd_q == hbp_pkg::CMD_CURSOR_SET)
                      && (pidx_q == 8'h01);

    // ----------------------------------------------------------------
    // cursor stepping
    // ----------------------------------------------------------------
    wire [15:0] step = (dir_q == hbp_pkg::DIR_RIGHT) ? 16'h0001 :
                       (dir_q == hbp_pkg::DIR_LEFT)  ? 16'hFFFF :
                       (dir_q == hbp_pkg::DIR_UP)    ? 16'(-row_pitch_i) :
                       row_pitch_i;                                    // RULE_18
    wire [15:0] ahead     = cursor_shown_i ? 16'(step << 1) : 16'h0000; // RULE_05
    wire        fifo_ready;
    wire        mw_push   = dat_wr && (mode_q == hbp_pkg::HBP_MEMORY_WRITE_CMD) && fifo_ready;
    wire        mr_step   = dat_rd && (mode_q == hbp_pkg::HBP_MEMORY_READ_CMD);
    wire        auto_step = mw_push || mr_step;
    wire [15:0] cursor_nx = cursor_q + step;

    // ----------------------------------------------------------------
    // write stream buffer and memory port
    // ----------------------------------------------------------------
    wire        fifo_valid;
    wire [23:0] fifo_data;
    wire        fifo_pop  = fifo_valid && mem_ack_i;
    // pending writes drain before a fetch, so a read sees earlier writes
    wire        fetch_go  = fetch_pend_q && !fifo_valid && mem_ack_i;

    hbp_fifo #(
        .WIDTH (hbp_pkg::FIFO_WIDTH),
        .DEPTH (hbp_pkg::FIFO_DEPTH)
    ) hbp_fifo_i (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (mw_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({cursor_q, wr_data_q}),                          // RULE_01
        .out_valid_o (fifo_valid),
        .out_ready_i (mem_ack_i),
        .out_data_o  (fifo_data)
    );

    assign mem_req_o          = fifo_valid || fetch_pend_q;
    assign mem_we_o           = fifo_valid;
    assign mem_addr_o         = fifo_valid ? fifo_data[23:8] : fetch_addr_q;
    assign mem_wdata_o        = fifo_data[7:0];
    assign host_write_ready_o = fifo_ready;

    // ----------------------------------------------------------------
    // read data and bus drive
    // ----------------------------------------------------------------
    wire [7:0] status_byte = 8'(flag_q) << hbp_pkg::STATUS_FLAG_BIT;   // RULE_10
    wire [7:0] data_byte   = (mode_q == hbp_pkg::HBP_CGET) ?
                             (cget_hi_q ? cursor_q[15:8] : cursor_q[7:0]) : buf_q; // RULE_20
    wire [7:0] out_d       = register_select_i ? data_byte : status_byte;

    assign data_o        = out_q;
    assign data_oe_b_o   = !(rd_act && rd_act_q);                      // RULE_21
    assign cmd_valid_o   = cmd_take;
    assign cmd_code_o    = wr_data_q;
    assign param_valid_o = param_take;
    assign param_data_o  = wr_data_q;
    assign param_index_o = pidx_q;
    assign sleep_o       = sleep_q;
    assign cursor_addr_o = cursor_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_act_q  <= 1'b0;
            wr_act_q  <= 1'b0;
            rd_sel_q  <= 1'b0;
            wr_sel_q  <= 1'b0;
            wr_data_q <= 8'h00;
            out_q     <= 8'h00;
            flag_q    <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            flag_q   <= !scan_reading_i;                               // RULE_11
            if (rd_act) begin
                rd_sel_q <= register_select_i;
                out_q    <= out_d;
            end
            if (wr_act) begin
                wr_sel_q  <= register_select_i;
                wr_data_q <= data_i;
            end
        end
    end

    // command state settles in the cycle after its strobe ends; the memory read preload waits for the memory
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q     <= hbp_pkg::HBP_PARAM;
            last_cmd_q <= hbp_pkg::CMD_RST;
            pidx_q     <= 8'h00;
            sleep_q    <= 1'b0;
            dir_q      <= hbp_pkg::DIR_RST;
            cget_hi_q  <= 1'b0;
        end else if (cmd_take) begin                                   // RULE_09
            last_cmd_q <= wr_data_q;
            pidx_q     <= 8'h00;
            cget_hi_q  <= 1'b0;
            mode_q     <= is_memory_write_cmd ? hbp_pkg::HBP_MEMORY_WRITE_CMD :
                          is_memory_read_cmd  ? hbp_pkg::HBP_MEMORY_READ_CMD  :
                          is_cget   ? hbp_pkg::HBP_CGET   : hbp_pkg::HBP_PARAM;
            if (wr_data_q == hbp_pkg::CMD_SLEEP_ENTRY) begin
                sleep_q <= 1'b1;
            end else if (wr_data_q == hbp_pkg::CMD_SYS_CONFIG) begin
                sleep_q <= 1'b0;
            end
            if (is_dir) begin
                dir_q <= wr_data_q[1:0];
            end
        end else begin
            if (param_take) begin
                pidx_q <= pidx_q + 8'h01;
            end
            if (dat_rd && mode_q == hbp_pkg::HBP_CGET) begin
                cget_hi_q <= !cget_hi_q;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cursor_q <= hbp_pkg::CURSOR_RST;
        end else if (cset_lo) begin                                    // RULE_19
            cursor_q[7:0] <= wr_data_q;
        end else if (cset_hi) begin
            cursor_q[15:8] <= wr_data_q;
        end else if (auto_step) begin
            cursor_q <= cursor_nx;                                     // RULE_01 RULE_04
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fetch_pend_q <= 1'b0;
            fetch_addr_q <= hbp_pkg::CURSOR_RST;
            buf_q        <= 8'h00;
        end else if (is_memory_read_cmd) begin
            fetch_pend_q <= 1'b1;                                      // RULE_03
            fetch_addr_q <= cursor_q + ahead;
        end else if (mr_step) begin
            fetch_pend_q <= 1'b1;                                      // RULE_04
            fetch_addr_q <= cursor_nx + ahead;
        end else if (fetch_go) begin
            fetch_pend_q <= 1'b0;
            buf_q        <= mem_rdata_i;
        end
    end
endmodule : hbp_port

// ---- tb/hbp_port_checker.sv ----
// assertions on the host bus port
`timescale 1ns/100ps
module hbp_port_checker (
    input wire logic        clock_i,
    input wire logic        rst_b_i,
    input wire logic        bus_style_select_a_i,
    input wire logic        bus_style_select_b_i,
    input wire logic        chip_select_b_i,
    input wire logic        register_select_i,
    input wire logic        strobe_a_i,
    input wire logic        strobe_b_i,
    input wire logic [7:0]  data_i,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_b_o,
    input wire logic        scan_reading_i,
    input wire logic        mem_req_o,
    input wire logic        mem_we_o,
    input wire logic        cmd_valid_o,
    input wire logic [7:0]  cmd_code_o,
    input wire logic        param_valid_o,
    input wire logic [7:0]  param_data_o,
    input wire logic        sleep_o,
    input wire logic [15:0] cursor_addr_o
);
    wire dir_w = bus_style_select_a_i && !bus_style_select_b_i;
    wire rd_w  = !chip_select_b_i
                 && (dir_w ? strobe_b_i && strobe_a_i : !strobe_a_i && strobe_b_i);
    wire wr_w  = !chip_select_b_i
                 && (dir_w ? strobe_b_i && !strobe_a_i : strobe_a_i && !strobe_b_i);
    wire acc_w = rd_w || wr_w;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // a command write has just been released
    sequence s_cmd_end;
        !wr_w && $past(wr_w) && $past(register_select_i);
    endsequence
    property p_oe_only_read;
        !data_oe_b_o |-> rd_w && $past(rd_w);
    endproperty
    a_oe_only_read: assert property (p_oe_only_read) else $error("bus driven off read");
    property p_oe_on_read;
        rd_w && $past(rd_w) |-> !data_oe_b_o;
    endproperty
    a_oe_on_read: assert property (p_oe_on_read) else $error("bus idle in a read");
    property p_status;
        rd_w && $past(rd_w) && !register_select_i && $stable(scan_reading_i)
            && $past(scan_reading_i, 2) == scan_reading_i |-> data_o[6] == !scan_reading_i;
    endproperty
    a_status: assert property (p_status) else $error("status flag wrong");
    property p_cmd;
        s_cmd_end ##0 !sleep_o |-> cmd_valid_o && cmd_code_o == $past(data_i);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not taken");
    property p_refuse;
        s_cmd_end ##0 (sleep_o && $past(data_i) != hbp_pkg::CMD_SYS_CONFIG
            && $past(data_i) != hbp_pkg::CMD_SLEEP_ENTRY) |-> !cmd_valid_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken in sleep");
    // a parameter pulse only ever follows the end of a data-side write
    property p_param;
        param_valid_o |-> !wr_w && $past(wr_w) && !$past(register_select_i)
            && param_data_o == $past(data_i);
    endproperty
    a_param: assert property (p_param) else $error("parameter without write");
    property p_sleep_rise;
        $rose(sleep_o) |-> $past(cmd_valid_o) && $past(cmd_code_o) == hbp_pkg::CMD_SLEEP_ENTRY;
    endproperty
    a_sleep_rise: assert property (p_sleep_rise) else $error("sleep without command");
    property p_cursor;
        $changed(cursor_addr_o) |-> $past(acc_w, 2) || $past(acc_w, 3) || $past(acc_w, 4);
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor moved on its own");
    property p_memory_read_cmd;
        s_cmd_end ##0 ($past(data_i) == hbp_pkg::CMD_MEM_READ && !sleep_o)
            |-> ##[1:40] (mem_req_o && !mem_we_o);
    endproperty
    a_memory_read_cmd: assert property (p_memory_read_cmd) else $error("no preload fetch");
endmodule : hbp_port_checker
bind hbp_port hbp_port_checker hbp_port_checker_i (.*);

// ---- tb/hbp_mem_model.sv ----
// display memory model answering the port's memory requests
`timescale 1ns/100ps
module hbp_mem_model (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic             mem_ack_o,
    output logic      [7:0]  mem_rdata_o
);
    // mode 0 grants at once, 1 after three waits, 2 stalls for good
    logic [7:0] mem_q [256];
    logic [1:0] wait_q;
    logic       tgl_q;
    initial for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'hC3;
    assign mem_ack_o = mem_req_i && mode_i != 2'h2 && wait_q == (mode_i[0] ? 2'h3 : 2'h0);
    // off the grant the lines wander so that a late sample cannot pass
    assign mem_rdata_o = (mem_ack_o && !mem_we_i) ? mem_q[mem_addr_i[7:0]] : {8{tgl_q}} ^ 8'h5A;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_q <= 2'h0;
            tgl_q  <= 1'b0;
        end else begin
            tgl_q  <= !tgl_q;
            wait_q <= (mem_req_i && !mem_ack_o) ? wait_q + 2'h1 : 2'h0;
            if (mem_ack_o && mem_we_i) mem_q[mem_addr_i[7:0]] <= mem_wdata_i;
        end
    end
endmodule : hbp_mem_model

// ---- tb/hbp_port_tb.sv ----
// self-checking bench for the host bus port
`timescale 1ns/100ps
module hbp_port_tb;
    logic clock_i = 1'b0, rst_b_i = 1'b0, bus_style_select_a_i = 1'b0;
    logic bus_style_select_b_i = 1'b0, chip_select_b_i = 1'b1, register_select_i = 1'b0;
    logic strobe_a_i = 1'b1, strobe_b_i = 1'b1, scan_reading_i = 1'b0, cursor_shown_i = 1'b0;
    logic [7:0] data_i = 8'h00;
    logic [15:0] row_pitch_i = 16'h0010;
    logic [1:0] mm = 2'h0;
    logic [7:0] data_o, mem_wdata_o, mem_rdata_i;
    logic [15:0] mem_addr_o, cursor_addr_o;
    logic data_oe_b_o, host_write_ready_o, mem_req_o, mem_we_o, mem_ack_i, sleep_o;
    int mismatches = 0, cmp_count = 0;
    wire dm = bus_style_select_a_i && !bus_style_select_b_i;
    always #50 clock_i = ~clock_i;
    hbp_port hbp_port_i (.*, .cmd_valid_o(), .cmd_code_o(), .param_valid_o(),
        .param_data_o(), .param_index_o());
    hbp_mem_model hbp_mem_model_i (.clock_i(clock_i), .rst_b_i(rst_b_i), .mode_i(mm),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // two active cycles then ten idle ones, room for the write drain and the next prefetch
    task automatic access(input logic sel, input logic rd, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clock_i);
        #1;
        chip_select_b_i = 1'b0;
        register_select_i = sel;
        data_i = d;
        strobe_a_i = dm ? rd : !rd;
        strobe_b_i = dm ? 1'b1 : rd;
        repeat (2) @(posedge clock_i);
        #1;
        q = data_o;
        if (rd) check(16'(data_oe_b_o), 16'h0000);
        chip_select_b_i = 1'b1;
        strobe_a_i = 1'b1;
        strobe_b_i = !dm;
        repeat (10) @(posedge clock_i);
        #1;
    endtask : access
    task automatic put(input logic sel, input logic [7:0] d);
        logic [7:0] q;
        access(sel, 1'b0, d, q);
    endtask : put
    task automatic get(input logic sel, output logic [7:0] q);
        access(sel, 1'b1, 8'h00, q);
    endtask : get
    task automatic set_cursor(input logic [15:0] a);
        put(1'b1, hbp_pkg::CMD_CURSOR_SET);
        put(1'b0, a[7:0]);
        put(1'b0, a[15:8]);
    endtask : set_cursor
    task automatic wait_idle();
        int k;
        k = 0;
        while (mem_req_o !== 1'b0 && k < 500) begin
            @(posedge clock_i);
            k++;
        end
        #1;
        if (k >= 500) begin
            mismatches++;
            finish_test();
        end
    endtask : wait_idle
    initial begin
        logic [7:0] q, b, e;
        logic [15:0] st;
        repeat (20) @(posedge clock_i);
        #1;
        rst_b_i = 1'b1;
        for (int s = 0; s < 2; s++) begin
            bus_style_select_a_i = s[0];
            strobe_b_i = !s[0];
            for (int d = 0; d < 4; d++) begin
                st = d == 0 ? 16'h0001 : d == 1 ? 16'hFFFF : d == 2 ? -row_pitch_i : row_pitch_i;
                e = 8'(16 * d + 4 * s);
                mm = 2'(d % 2);
                cursor_shown_i = 1'b0;
                scan_reading_i = 1'b0;
                put(1'b1, {hbp_pkg::CMD_STEP_DIR_TOP, 2'(d)});
                set_cursor(16'h0080);
                put(1'b1, hbp_pkg::CMD_MEM_WRITE);
                for (int i = 0; i < 3; i++) put(1'b0, e + 8'(i));
                check(cursor_addr_o, 16'(16'h0080 + 3 * st));
                set_cursor(16'h0080);
                put(1'b1, hbp_pkg::CMD_MEM_READ);
                for (int i = 0; i < 3; i++) begin
                    get(1'b1, q);
                    check(16'(q), 16'(e + 8'(i)));
                end
                put(1'b1, hbp_pkg::CMD_CURSOR_GET);
                get(1'b1, q);
                get(1'b1, b);
                check({b, q}, 16'(16'h0080 + 3 * st));
                cursor_shown_i = 1'b1;
                set_cursor(16'h0080);
                put(1'b1, hbp_pkg::CMD_MEM_READ);
                get(1'b1, q);
                check(16'(q), 16'(e + 8'h02));
            end
            for (int f = 0; f < 2; f++) begin
                scan_reading_i = f[0];
                get(1'b0, q);
                check(16'(q[6]), 16'(!f[0]));
            end
        end
        bus_style_select_a_i = 1'b1;
        bus_style_select_b_i = 1'b1;
        strobe_b_i = 1'b1;
        cursor_shown_i = 1'b0;
        scan_reading_i = 1'b0;
        put(1'b1, {hbp_pkg::CMD_STEP_DIR_TOP, hbp_pkg::DIR_RIGHT});
        set_cursor(16'h0000);
        mm = 2'h2;
        put(1'b1, hbp_pkg::CMD_MEM_WRITE);
        for (int i = 0; i < 18; i++) put(1'b0, 8'(i));
        check(16'(host_write_ready_o), 16'h0000);
        check(cursor_addr_o, 16'h0010);
        mm = 2'h1;
        wait_idle();
        check(16'(host_write_ready_o), 16'h0001);
        set_cursor(16'h000F);
        put(1'b1, hbp_pkg::CMD_MEM_READ);
        get(1'b1, q);
        check(16'(q), 16'h000F);
        get(1'b1, q);
        check(16'(q), 16'h00D3);
        wait_idle();
        put(1'b1, hbp_pkg::CMD_SLEEP_ENTRY);
        check(16'(sleep_o), 16'h0001);
        set_cursor(16'h1234);
        check(cursor_addr_o, 16'h0011);
        put(1'b1, hbp_pkg::CMD_SYS_CONFIG);
        check(16'(sleep_o), 16'h0000);
        set_cursor(16'h1234);
        check(cursor_addr_o, 16'h1234);
        finish_test();
    end
endmodule : hbp_port_tb
